// ==== include/atc_regs.vh ====
`ifndef ATC_REGS_VH
`define ATC_REGS_VH

`define ATC_OFS_CTRL_A 16'hff40
`define ATC_OFS_CTRL_B 16'hff44
`define ATC_OFS_COUNT_A 16'hff50
`define ATC_OFS_COUNT_B 16'hff54

`define ATC_CTRL_RESET 16'h0000
`define ATC_COUNT_RESET 16'h0000
`define ATC_CTRL_WR_MASK 16'h73ff

`define ATC_BIT_RDIR 15
`define ATC_BIT_CHDIR 14
`define ATC_BIT_EDGE 13
`define ATC_BIT_IRDIS 12
`define ATC_BIT_RC 9
`define ATC_BIT_UDE 8
`define ATC_BIT_UD 7
`define ATC_BIT_RUN 6
`define ATC_MODE_HI 5
`define ATC_MODE_LO 3
`define ATC_IP_HI 2
`define ATC_IP_LO 0

`define ATC_MODE_TIMER 3'h0
`define ATC_MODE_COUNTER 3'h1
`define ATC_MODE_GATE_LOW 3'h2
`define ATC_MODE_GATE_HIGH 3'h3
`define ATC_MODE_RELOAD 3'h4
`define ATC_MODE_CAPTURE 3'h5
`define ATC_MODE_INC_ROT 3'h6
`define ATC_MODE_INC_EDGE 3'h7

`define ATC_PRESCALE_BASE 3

`endif

// ==== src/atc_aux_timer_control.v ====
// How it works
// - Two identical timers: timer, gated, counter and incremental modes.
// - Count register reads current count; a write loads a new count.
// - Mode field bits 5..3 selects one of eight modes.
// - Input field bits 2..0 is prescaler or edge choice per mode.
// - Local run bit 6 starts or stops, only while remote select is 0.
// - Remote select bit 9 hands run control to the core run bit.
// - The selected run bit gates counting in every mode.
// - Gated modes count only with run set and gate at active level.
// - Core run bit starts remote timers in the same clock cycle.
// - Software direction bit 7: 0 counts up, 1 counts down.
// - External direction enable bit 8 connects the direction pin.
// - Read-only bit 15 shows current direction, 1 for down.
// - Bit 14 is set on direction change, kept until written 0.
// - Bit 13 is set on each count edge, kept until cleared.
// - Bit 12 disables incremental mode interrupt requests.
// - No output toggle latch and no alternate output pin.
// - Both control registers share one layout; bits 11, 10 unused.
// - Mode 010 runs while the gate is low, stops while high.
// - Mode 110 requests on direction change, 111 on each count edge.
// - Incremental direction follows the quadrature input order.
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
`include "atc_regs.vh"
`default_nettype none

module atc_aux_timer_control #(
  parameter integer PRESCALE_BASE = `ATC_PRESCALE_BASE
) (
  input wire clk,
  input wire nrst,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire core_run_bit,
  input wire core_toggle_latch,
  input wire count_gate_input_pin_a,
  input wire external_direction_pin_a,
  input wire count_gate_input_pin_b,
  input wire external_direction_pin_b,
  output reg irq_a,
  output reg irq_b
);

  // Low bits of the shared prescaler all ones marks a timer tick.
  function prescale_tick;
    input [15:0] pre;
    input [2:0] ip;
    reg [15:0] mask;
    begin
      mask = ~(16'hffff << (PRESCALE_BASE + ip));
      prescale_tick = ((pre & mask) == mask);
    end
  endfunction

  // Edge select: 01 rising, 10 falling, 11 either, 00 none.
  function edge_hit;
    input [1:0] sel;
    input now;
    input was;
    begin
      case (sel)
        2'h1: edge_hit = now & ~was;
        2'h2: edge_hit = ~now & was;
        2'h3: edge_hit = now ^ was;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  reg [15:0] ctrl [0:1];
  reg [15:0] count [0:1];
  reg [15:0] pre;
  reg [1:0] gate_prev;
  reg [1:0] eud_prev;
  reg toggle_prev;
  reg [1:0] inc_down;

  reg [15:0] next_ctrl [0:1];
  reg [15:0] next_count [0:1];
  reg [1:0] next_inc_down;
  reg [1:0] next_irq;

  reg [1:0] gate_in;
  reg [1:0] eud_in;
  reg [2:0] mode;
  reg [2:0] ip;
  reg run;
  reg tick;
  reg down;
  reg in_edge;
  reg eud_edge;
  reg ctrl_wr;
  reg count_wr;
  integer i;

  wire access = psel & penable & pready;
  wire wr_en = access & pwrite;
  wire hit_ctrl_a = (paddr == `ATC_OFS_CTRL_A);
  wire hit_ctrl_b = (paddr == `ATC_OFS_CTRL_B);
  wire hit_count_a = (paddr == `ATC_OFS_COUNT_A);
  wire hit_count_b = (paddr == `ATC_OFS_COUNT_B);
  wire mapped = hit_ctrl_a | hit_ctrl_b | hit_count_a | hit_count_b;

  always @* begin
    gate_in = {count_gate_input_pin_b, count_gate_input_pin_a};
    eud_in = {external_direction_pin_b, external_direction_pin_a};
    next_inc_down = inc_down;
    next_irq = 2'h0;
    mode = 3'h0;
    ip = 3'h0;
    run = 1'b0;
    tick = 1'b0;
    down = 1'b0;
    in_edge = 1'b0;
    eud_edge = 1'b0;
    ctrl_wr = 1'b0;
    count_wr = 1'b0;
    // Both timers share one body so they cannot drift apart.
    for (i = 0; i < 2; i = i + 1) begin
      next_ctrl[i] = ctrl[i];
      next_count[i] = count[i];
      mode = ctrl[i][`ATC_MODE_HI:`ATC_MODE_LO];
      ip = ctrl[i][`ATC_IP_HI:`ATC_IP_LO];
      // The core run bit is used directly, so remote timers start in the
      // same cycle as the core timer.
      if (ctrl[i][`ATC_BIT_RC]) begin
        run = core_run_bit;
      end else begin
        run = ctrl[i][`ATC_BIT_RUN];
      end
      in_edge = gate_in[i] ^ gate_prev[i];
      eud_edge = eud_in[i] ^ eud_prev[i];
      tick = 1'b0;
      case (mode)
        `ATC_MODE_TIMER: begin
          tick = prescale_tick(pre, ip);
        end
        `ATC_MODE_GATE_LOW: begin
          tick = prescale_tick(pre, ip) & ~gate_in[i];
        end
        `ATC_MODE_GATE_HIGH: begin
          tick = prescale_tick(pre, ip) & gate_in[i];
        end
        `ATC_MODE_COUNTER: begin
          if (ip[2]) begin
            tick = edge_hit(ip[1:0], core_toggle_latch, toggle_prev);
          end else begin
            tick = edge_hit(ip[1:0], gate_in[i], gate_prev[i]);
          end
        end
        `ATC_MODE_INC_ROT, `ATC_MODE_INC_EDGE: begin
          if (!ip[2]) begin
            // Quadrature decode: the edge on one input against the level
            // of the other gives the direction.
            if (ip[0] && in_edge) begin
              tick = 1'b1;
              next_inc_down[i] = ~(gate_in[i] ^ eud_in[i]);
            end else if (ip[1] && eud_edge) begin
              tick = 1'b1;
              next_inc_down[i] = eud_in[i] ^ gate_in[i];
            end
          end
        end
        default: begin
          // Reload and capture hold the count regardless of run.
          tick = 1'b0;
        end
      endcase
      tick = tick & run;
      if (mode == `ATC_MODE_INC_ROT || mode == `ATC_MODE_INC_EDGE) begin
        down = next_inc_down[i];
      end else if (ctrl[i][`ATC_BIT_UDE]) begin
        down = ctrl[i][`ATC_BIT_UD] ^ eud_in[i];
      end else begin
        down = ctrl[i][`ATC_BIT_UD];
      end
      if (tick) begin
        if (down) begin
          next_count[i] = count[i] - 16'h0001;
        end else begin
          next_count[i] = count[i] + 16'h0001;
        end
      end
      ctrl_wr = wr_en & (i == 0 ? hit_ctrl_a : hit_ctrl_b);
      count_wr = wr_en & (i == 0 ? hit_count_a : hit_count_b);
      if (count_wr) begin
        next_count[i] = pwdata[15:0];
      end
      if (ctrl_wr) begin
        next_ctrl[i] = (pwdata[15:0] & `ATC_CTRL_WR_MASK) |
                       (ctrl[i] & ~`ATC_CTRL_WR_MASK);
      end
      // Hardware set wins over a software clear in the same cycle.
      if (down != ctrl[i][`ATC_BIT_RDIR]) begin
        next_ctrl[i][`ATC_BIT_CHDIR] = 1'b1;
        if (mode == `ATC_MODE_INC_ROT && !ctrl[i][`ATC_BIT_IRDIS]) begin
          next_irq[i] = 1'b1;
        end
      end
      if (tick) begin
        next_ctrl[i][`ATC_BIT_EDGE] = 1'b1;
        if (mode == `ATC_MODE_INC_EDGE && !ctrl[i][`ATC_BIT_IRDIS]) begin
          next_irq[i] = 1'b1;
        end
      end
      next_ctrl[i][`ATC_BIT_RDIR] = down;
      next_ctrl[i][11:10] = 2'h0;
    end
  end

  // Timer state. Only irq_a and irq_b are driven here: there is no toggle latch.
  always @(posedge clk) begin
    if (!nrst) begin
      ctrl[0] <= `ATC_CTRL_RESET;
      ctrl[1] <= `ATC_CTRL_RESET;
      count[0] <= `ATC_COUNT_RESET;
      count[1] <= `ATC_COUNT_RESET;
      pre <= 16'h0000;
      gate_prev <= 2'h0;
      eud_prev <= 2'h0;
      toggle_prev <= 1'b0;
      inc_down <= 2'h0;
      irq_a <= 1'b0;
      irq_b <= 1'b0;
    end else if (clk_en) begin
      ctrl[0] <= next_ctrl[0];
      ctrl[1] <= next_ctrl[1];
      count[0] <= next_count[0];
      count[1] <= next_count[1];
      pre <= pre + 16'h0001;
      gate_prev <= gate_in;
      eud_prev <= eud_in;
      toggle_prev <= core_toggle_latch;
      inc_down <= next_inc_down;
      irq_a <= next_irq[0];
      irq_b <= next_irq[1];
    end
  end

  // One wait state keeps prdata and pready straight from flip-flops.
  always @(posedge clk) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel & penable & ~pready & ~pwrite) begin
        if (hit_ctrl_a) begin
          prdata <= {16'h0000, ctrl[0]};
        end else if (hit_ctrl_b) begin
          prdata <= {16'h0000, ctrl[1]};
        end else if (hit_count_a) begin
          prdata <= {16'h0000, count[0]};
        end else if (hit_count_b) begin
          prdata <= {16'h0000, count[1]};
        end else begin
          prdata <= 32'h00000000;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== testbench/atc_checker_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module atc_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic count_gate_input_pin_a,
  input wire logic external_direction_pin_a,
  input wire logic irq_a
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst || !clk_en);
  logic [1:0] pins_q;
  logic [3:0] moved;
  wire [1:0] pins = {count_gate_input_pin_a, external_direction_pin_a};
  wire ctl = paddr == 16'hff40 || paddr == 16'hff44;
  wire hit = ctl || paddr == 16'hff50 || paddr == 16'hff54;
  // An interrupt needs pin activity within the last four cycles.
  always @(posedge clk) begin
    pins_q <= pins;
    moved <= {moved[2:0], pins != pins_q};
  end
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_READY_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("no ready one cycle into access");
  AST_READY_CAUSE: assert property (pready |-> psel && $past(penable))
    else $error("ready without access");
  AST_UNMAPPED_ERR: assert property (pready && !hit |-> pslverr)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (pready && hit |-> !pslverr)
    else $error("mapped access refused");
  AST_ERR_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  AST_CTL_GAP_ZERO: assert property (pready && !pwrite && ctl |-> prdata[11:10] == 2'h0 && prdata[31:16] == 16'h0)
    else $error("unused control bits not zero");
  AST_IRQ_CAUSE: assert property (irq_a |-> moved != 4'h0)
    else $error("interrupt without pin activity");
  cover property (pready && pwrite && !pslverr);
  cover property (pready && pslverr);
  cover property (irq_a);
endmodule
`default_nettype wire

// ==== testbench/atc_encoder.sv ====
`timescale 1ns/100ps
`default_nettype none
module atc_encoder (
  input wire logic clk,
  input wire logic step,
  input wire logic down,
  output logic qa,
  output logic qb
);
  logic [1:0] pos = 2'h0;
  always @(posedge clk) begin
    if (step) begin
      pos <= down ? pos - 2'h1 : pos + 2'h1;
    end
  end
  // Gray order: moving up, the count input leads the other.
  assign qa = pos[1] ^ pos[0];
  assign qb = pos[1];
endmodule
`default_nettype wire

// ==== testbench/atc_aux_timer_control_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module atc_aux_timer_control_bench;
  localparam logic [15:0] ctl_a = 16'hff40;
  localparam logic [15:0] ctl_b = 16'hff44;
  localparam logic [15:0] cnt_a = 16'hff50;
  localparam logic [15:0] cnt_b = 16'hff54;
  logic clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, core_run = 1'h0, err, pready, pslverr, irq_a, irq_b;
  logic qa_a, qb_a, qa_b, qb_b;
  logic clk_en = 1'h1;
  logic [15:0] d0;
  logic [15:0] paddr = 16'h0, r, c1;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [1:0] stp = 2'h0, dn = 2'h0;
  int mismatches = 0, total_checks = 0, n_ia = 0, n_ib = 0;
  always #50 clk = ~clk;
  always @(posedge clk) begin
    n_ia <= n_ia + int'(irq_a === 1'h1);
    n_ib <= n_ib + int'(irq_b === 1'h1);
  end
  atc_encoder u_enc_a (.clk, .step(stp[0]), .down(dn[0]), .qa(qa_a), .qb(qb_a));
  atc_encoder u_enc_b (.clk, .step(stp[1]), .down(dn[1]), .qa(qa_b), .qb(qb_b));
  atc_aux_timer_control #(.PRESCALE_BASE(0)) u_dut (
    .clk, .nrst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .core_run_bit(core_run),
    .core_toggle_latch(1'h0), .count_gate_input_pin_a(qa_a),
    .external_direction_pin_a(qb_a), .count_gate_input_pin_b(qa_b),
    .external_direction_pin_b(qb_b), .irq_a, .irq_b);
  task automatic chk(input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    r = prdata[15:0];
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, e);
    apb(1'h0, a, 16'h0);
    chk({16'h0, r}, {16'h0, e});
  endtask
  task automatic twice;
    apb(1'h0, cnt_a, 16'h0);
    c1 = r;
    apb(1'h0, cnt_a, 16'h0);
  endtask
  // Encoder pins settle for a few cycles so sampled edges are all counted.
  task automatic mv(input logic [1:0] s, d, input int n);
    dn <= d;
    stp <= s;
    repeat (n) @(posedge clk);
    stp <= 2'h0;
    repeat (4) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    rd(ctl_b, 16'h0);
    rd(cnt_a, 16'h0);
    apb(1'h0, 16'hff48, 16'h0);
    chk({15'h0, err, r}, 32'h10000);
    apb(1'h1, ctl_a, 16'h0e80);
    rd(ctl_a, 16'hc280);
    apb(1'h1, ctl_a, 16'h0);
    rd(ctl_a, 16'h4000);
    apb(1'h1, cnt_a, 16'h0100);
    rd(cnt_a, 16'h0100);
    $display("register test done");
    apb(1'h1, ctl_a, 16'h0173);
    mv(2'h1, 2'h0, 4);
    rd(cnt_a, 16'h0104);
    rd(ctl_a, 16'h2173);
    mv(2'h1, 2'h1, 2);
    rd(cnt_a, 16'h0102);
    rd(ctl_a, 16'he173);
    chk(n_ia, 1);
    apb(1'h1, ctl_a, 16'h1173);
    mv(2'h1, 2'h0, 1);
    rd(ctl_a, 16'h7173);
    chk(n_ia, 1);
    apb(1'h1, ctl_b, 16'h037b);
    mv(2'h2, 2'h0, 2);
    rd(cnt_b, 16'h0);
    core_run <= 1'h1;
    mv(2'h2, 2'h0, 2);
    rd(cnt_b, 16'h0002);
    chk(n_ib, 2);
    core_run <= 1'h0;
    $display("incremental test done");
    apb(1'h1, ctl_a, 16'h0050);
    twice();
    chk(r > c1, 1);
    apb(1'h1, ctl_a, 16'h00d0);
    twice();
    chk(r < c1, 1);
    apb(1'h1, ctl_a, 16'h0058);
    twice();
    chk(r, c1);
    apb(1'h1, ctl_a, 16'h0040);
    twice();
    chk(r > c1, 1);
    d0 = r - c1;
    apb(1'h0, cnt_a, 16'h0);
    c1 = r;
    clk_en <= 1'h0;
    repeat (20) @(posedge clk);
    clk_en <= 1'h1;
    apb(1'h0, cnt_a, 16'h0);
    chk({16'h0, r - c1}, {16'h0, d0});
    apb(1'h1, ctl_a, 16'h0000);
    twice();
    chk(r, c1);
    apb(1'h1, ctl_a, 16'h004b);
    apb(1'h1, cnt_a, 16'h0000);
    mv(2'h1, 2'h0, 4);
    rd(cnt_a, 16'h0002);
    $display("timer test done");
    end_of_test();
  end
endmodule
bind atc_aux_timer_control atc_checker u_chk (.clk, .nrst, .clk_en, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .count_gate_input_pin_a, .external_direction_pin_a, .irq_a);
`default_nettype wire
